// file: common/mdu_pkg.sv
// Purpose: Shared constants and types for the MIDI UART emulation block
// Assumes: 100 MHz system clock, byte-wide host I/O port
// Notes: Host address is a 10-bit I/O address; the base is a parameter of the top
package mdu_pkg;
  // Register offsets from the port base
  localparam logic [0:0] DATA_OFS = 1'h0;
  localparam logic [0:0] CMDSTAT_OFS = 1'h1;
  // Status field positions
  localparam int TX_FULL_BIT = 6;
  localparam int RX_EMPTY_BIT = 7;
  localparam int CMD_ECHO_W = 6;
  // Queue depths
  localparam int TX_DEPTH = 64;
  localparam int RX_DEPTH = 16;
  // Command and reply codes
  localparam logic [7:0] CMD_ENTER_UART = 8'h3f;
  localparam logic [7:0] CMD_LEAVE_UART = 8'hff;
  localparam logic [7:0] ACK_BYTE = 8'hfe;
  localparam logic [7:0] REPLY_ZERO = 8'h00;
  localparam logic [7:0] REPLY_AC = 8'h15;
  localparam logic [7:0] REPLY_AD = 8'h01;
  localparam logic [7:0] REPLY_AF = 8'h64;
  // Bit timing: baud in Hz, clock in Hz, 16x oversampling on receive
  localparam int CLK_HZ = 100_000_000;
  localparam int BAUD_HZ = 31_250;
  localparam int BIT_CYCLES = CLK_HZ / BAUD_HZ;
  localparam int OVS = 16;
  localparam int OVS_CYCLES = BIT_CYCLES / OVS;
  localparam int CHAR_DATA_BITS = 8;
  // Reset values
  localparam logic RST_UART_MODE = 1'b0;
  localparam logic [7:0] RST_BYTE = 8'h00;

  // Host I/O request
  typedef struct packed {
    logic rd;
    logic wr;
    logic [9:0] addr;
    logic [7:0] wdata;
  } mdu_host_req_s;

  typedef enum {TX_IDLE, TX_START, TX_DATA, TX_STOP} mdu_tx_e;
  typedef enum {RX_IDLE, RX_START, RX_DATA, RX_STOP} mdu_rx_e;
endpackage

// file: rtl/mdu_fifo.sv
// Purpose: Synchronous FIFO with valid/ready on both sides
// Assumes: One clock, synchronous active-low reset
// Notes: Optional overwrite of the newest slot when full
`timescale 1ns/1ps
module mdu_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic sys_clk, // System clock
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic inValid, // Write request
  output logic inReady, // Space available
  input wire logic [WIDTH-1:0] inData, // Write data
  input wire logic overwrite, // When full, replace the newest entry
  output logic outValid, // Data available
  input wire logic outReady, // Pop request
  output logic [WIDTH-1:0] outData, // Head data
  output logic full, // Queue is full
  output logic empty // Queue is empty
);
  localparam int AW = $clog2(DEPTH);

  // Elaboration check; pointer wrap logic needs a power-of-two depth
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("mdu_fifo: DEPTH must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wrPtr_q;
  logic [AW:0] rdPtr_q;
  logic doPush;
  logic doOver;
  logic doPop;

  // Pointer compare; extra bit separates full from empty
  assign empty = (wrPtr_q == rdPtr_q);
  assign full = (wrPtr_q[AW-1:0] == rdPtr_q[AW-1:0]) && (wrPtr_q[AW] != rdPtr_q[AW]);
  assign inReady = !full;
  assign outValid = !empty;
  assign outData = mem[rdPtr_q[AW-1:0]];
  assign doPop = outReady && !empty;
  assign doPush = inValid && (!full || doPop);
  assign doOver = inValid && full && !doPop && overwrite;

  // Storage; overwrite lands on the last written slot
  always_ff @(posedge sys_clk) begin
    if (doPush) begin
      mem[wrPtr_q[AW-1:0]] <= inData;
    end else if (doOver) begin
      mem[AW'(wrPtr_q[AW-1:0] - 1'b1)] <= inData;
    end
  end

  // Pointers
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
    end else begin
      if (doPush) begin
        wrPtr_q <= wrPtr_q + 1'b1;
      end
      if (doPop) begin
        rdPtr_q <= rdPtr_q + 1'b1;
      end
    end
  end
endmodule // mdu_fifo

// file: rtl/mdu_midi_uart.sv
// Purpose: Host-facing MIDI UART with command emulation and serial link
// Assumes: Host strobes are one-cycle pulses on sys_clk; serial in is asynchronous
// Notes: Two-byte replies to a one-byte command take two cycles to enter the receive queue
//
// What this block does
// - Transmit queue 64 bytes, receive queue 16
// - Serial link fixed at 31.25 kbaud
// - One start, eight data, one stop
// - Status low six bits echo last command
// - Status bit 6 shows transmit queue full
// - Status bit 7 shows receive queue empty
// - Every byte entering receive queue raises interrupt
// - Data port read clears the interrupt
// - Reset enters non-UART mode, data writes dropped
// - Command 3Fh enters UART mode, queues FEh
// - Listed commands queue FEh plus reply byte
// - Other commands only queue FEh
// - UART mode writes queue and transmit bytes
// - UART reads pop; full queue overwrites last
// - Command FFh leaves UART mode
// - Other commands in UART mode only set the echo
// - Two ports, ten-bit decode, no aliases
`timescale 1ns/1ps
module mdu_midi_uart #(
  parameter logic [9:0] PORT_BASE = 10'h330, // Base I/O address, even
  parameter int TX_QDEPTH = mdu_pkg::TX_DEPTH,
  parameter int RX_QDEPTH = mdu_pkg::RX_DEPTH
) (
  input wire logic sys_clk, // System clock 100 MHz
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic hostRd, // Read strobe, one cycle
  input wire logic hostWr, // Write strobe, one cycle
  input wire logic [15:0] hostAddr, // Host I/O address
  input wire logic [7:0] hostWdata, // Write data
  output logic [7:0] hostRdata, // Read data, valid the cycle after hostRd
  output logic hostIrq, // Interrupt request, active high level
  input wire logic midi_serial_in, // Serial input from opto-isolator
  output logic midi_serial_out // Serial output, idles high
);
  // Elaboration check; the two locations share all bits but the lowest
  if (PORT_BASE[0] != 1'b0) begin : g_bad_base
    $error("mdu_midi_uart: PORT_BASE must be even");
  end

  // ----------------------------------------------------------------
  // Host decode
  // ----------------------------------------------------------------
  mdu_pkg::mdu_host_req_s req;
  logic hit;
  logic selData;
  logic selCmd;

  // Upper address bits must be zero so no alias answers
  assign req = '{rd: hostRd, wr: hostWr, addr: hostAddr[9:0], wdata: hostWdata};
  assign hit = (hostAddr[15:10] == 6'h00) && (req.addr[9:1] == PORT_BASE[9:1]);
  assign selData = hit && (req.addr[0] == mdu_pkg::DATA_OFS);
  assign selCmd = hit && (req.addr[0] == mdu_pkg::CMDSTAT_OFS);

  // ----------------------------------------------------------------
  // Mode and command handling
  // ----------------------------------------------------------------
  logic uartMode_q;
  logic [5:0] cmdEcho_q;
  logic replyPend_q;
  logic [7:0] reply_q;
  logic cmdWr;
  logic cmdListed;
  logic [7:0] cmdReply;

  assign cmdWr = req.wr && selCmd;

  // Reply lookup for the listed intelligent-mode commands
  always_comb begin
    cmdListed = 1'b1;
    cmdReply = mdu_pkg::REPLY_ZERO;
    case (req.wdata)
      8'ha0, 8'ha1, 8'ha2, 8'ha3, 8'ha4, 8'ha5, 8'ha6, 8'ha7, 8'hab: cmdReply = mdu_pkg::REPLY_ZERO;
      8'hac: cmdReply = mdu_pkg::REPLY_AC;
      8'had: cmdReply = mdu_pkg::REPLY_AD;
      8'haf: cmdReply = mdu_pkg::REPLY_AF;
      default: cmdListed = 1'b0;
    endcase
  end

  // Mode flag
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      uartMode_q <= mdu_pkg::RST_UART_MODE;
    end else if (cmdWr) begin
      if (!uartMode_q && req.wdata == mdu_pkg::CMD_ENTER_UART) begin
        uartMode_q <= 1'b1;
      end else if (uartMode_q && req.wdata == mdu_pkg::CMD_LEAVE_UART) begin
        uartMode_q <= 1'b0;
      end
    end
  end

  // Echo of the last command, in either mode
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cmdEcho_q <= '0;
    end else if (cmdWr) begin
      cmdEcho_q <= req.wdata[mdu_pkg::CMD_ECHO_W-1:0];
    end
  end

  // Second reply byte follows the acknowledge one cycle later
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      replyPend_q <= 1'b0;
      reply_q <= mdu_pkg::RST_BYTE;
    end else begin
      replyPend_q <= cmdWr && !uartMode_q && cmdListed;
      reply_q <= cmdReply;
    end
  end

  // ----------------------------------------------------------------
  // Receive queue source select
  // ----------------------------------------------------------------
  logic rxByteValid;
  logic [7:0] rxByte;
  logic ackPush;
  logic rqInValid;
  logic [7:0] rqInData;
  logic rqOverwrite;
  logic rqPop;
  logic rqValid;
  logic [7:0] rqHead;
  logic rqEmpty;

  // Non-UART commands all acknowledge; UART-mode commands never do
  assign ackPush = cmdWr && !uartMode_q;
  // Acknowledges take priority; a serial byte landing the same cycle is lost.
  // Serial bytes are accepted only in UART mode.
  always_comb begin
    rqInValid = 1'b0;
    rqInData = mdu_pkg::ACK_BYTE;
    rqOverwrite = 1'b0;
    if (ackPush) begin
      rqInValid = 1'b1;
    end else if (replyPend_q) begin
      rqInValid = 1'b1;
      rqInData = reply_q;
    end else if (rxByteValid && uartMode_q) begin
      rqInValid = 1'b1;
      rqInData = rxByte;
      rqOverwrite = 1'b1;
    end
  end

  // Pops only in UART mode; non-UART reads just look at the head
  assign rqPop = req.rd && selData && uartMode_q;

  mdu_fifo #(.WIDTH(8), .DEPTH(RX_QDEPTH)) u_rx_q (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .inValid(rqInValid),
    .inReady(),
    .inData(rqInData),
    .overwrite(rqOverwrite),
    .outValid(rqValid),
    .outReady(rqPop),
    .outData(rqHead),
    .full(),
    .empty(rqEmpty)
  );

  // Last byte handed to the host, returned when the queue is empty
  logic [7:0] lastRx_q;
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      lastRx_q <= mdu_pkg::RST_BYTE;
    end else if (req.rd && selData && rqValid) begin
      lastRx_q <= rqHead;
    end
  end

  // ----------------------------------------------------------------
  // Transmit queue
  // ----------------------------------------------------------------
  logic tqPush;
  logic tqValid;
  logic [7:0] tqHead;
  logic tqFull;
  logic txTake;

  // Host writes are dropped outside UART mode and when full
  assign tqPush = req.wr && selData && uartMode_q;

  mdu_fifo #(.WIDTH(8), .DEPTH(TX_QDEPTH)) u_tx_q (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .inValid(tqPush),
    .inReady(),
    .inData(req.wdata),
    .overwrite(1'b0),
    .outValid(tqValid),
    .outReady(txTake),
    .outData(tqHead),
    .full(tqFull),
    .empty()
  );

  // ----------------------------------------------------------------
  // Host read data and interrupt
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      hostRdata <= mdu_pkg::RST_BYTE;
    end else if (req.rd && selCmd) begin
      hostRdata <= {rqEmpty, tqFull, cmdEcho_q};
    end else if (req.rd && selData) begin
      hostRdata <= rqValid ? rqHead : lastRx_q;
    end
  end

  // Set wins over the clearing read in the same cycle
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      hostIrq <= 1'b0;
    end else if (rqInValid) begin
      hostIrq <= 1'b1;
    end else if (req.rd && selData) begin
      hostIrq <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Serial transmitter
  // ----------------------------------------------------------------
  mdu_pkg::mdu_tx_e txState_q;
  logic [15:0] txCnt_q;
  logic [2:0] txBit_q;
  logic [7:0] txShift_q;
  logic txTick;

  assign txTick = (txCnt_q == 16'(mdu_pkg::BIT_CYCLES - 1));
  assign txTake = (txState_q == mdu_pkg::TX_IDLE) && tqValid;

  // Frame: start low, eight data LSB first, stop high
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      txState_q <= mdu_pkg::TX_IDLE;
      txCnt_q <= '0;
      txBit_q <= '0;
      txShift_q <= '0;
      midi_serial_out <= 1'b1;
    end else begin
      txCnt_q <= (txState_q == mdu_pkg::TX_IDLE || txTick) ? '0 : txCnt_q + 1'b1;
      case (txState_q)
        mdu_pkg::TX_IDLE: begin
          midi_serial_out <= 1'b1;
          if (txTake) begin
            txShift_q <= tqHead;
            midi_serial_out <= 1'b0;
            txState_q <= mdu_pkg::TX_START;
          end
        end
        mdu_pkg::TX_START: begin
          if (txTick) begin
            midi_serial_out <= txShift_q[0];
            txShift_q <= {1'b0, txShift_q[7:1]};
            txBit_q <= '0;
            txState_q <= mdu_pkg::TX_DATA;
          end
        end
        mdu_pkg::TX_DATA: begin
          if (txTick) begin
            if (txBit_q == 3'(mdu_pkg::CHAR_DATA_BITS - 1)) begin
              midi_serial_out <= 1'b1;
              txState_q <= mdu_pkg::TX_STOP;
            end else begin
              midi_serial_out <= txShift_q[0];
              txShift_q <= {1'b0, txShift_q[7:1]};
              txBit_q <= txBit_q + 1'b1;
            end
          end
        end
        mdu_pkg::TX_STOP: begin
          if (txTick) begin
            txState_q <= mdu_pkg::TX_IDLE;
          end
        end
        default: txState_q <= mdu_pkg::TX_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Serial receiver
  // ----------------------------------------------------------------
  logic rxMeta_q;
  logic rxSync_q;
  mdu_pkg::mdu_rx_e rxState_q;
  logic [7:0] ovsCnt_q;
  logic [3:0] phase_q;
  logic [2:0] rxBit_q;
  logic [7:0] rxShift_q;
  logic ovsTick;
  logic centre;

  // Two-stage synchroniser for the asynchronous input
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rxMeta_q <= 1'b1;
      rxSync_q <= 1'b1;
    end else begin
      rxMeta_q <= midi_serial_in;
      rxSync_q <= rxMeta_q;
    end
  end

  // 16x oversample tick; phase 7 is the bit centre
  assign ovsTick = (ovsCnt_q == 8'(mdu_pkg::OVS_CYCLES - 1));
  assign centre = ovsTick && (phase_q == 4'(mdu_pkg::OVS / 2 - 1));

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rxState_q <= mdu_pkg::RX_IDLE;
      ovsCnt_q <= '0;
      phase_q <= '0;
      rxBit_q <= '0;
      rxShift_q <= '0;
      rxByteValid <= 1'b0;
      rxByte <= mdu_pkg::RST_BYTE;
    end else begin
      rxByteValid <= 1'b0;
      ovsCnt_q <= (rxState_q == mdu_pkg::RX_IDLE || ovsTick) ? '0 : ovsCnt_q + 1'b1;
      if (ovsTick) begin
        phase_q <= phase_q + 1'b1;
      end
      case (rxState_q)
        mdu_pkg::RX_IDLE: begin
          phase_q <= '0;
          if (!rxSync_q) begin
            rxState_q <= mdu_pkg::RX_START;
          end
        end
        mdu_pkg::RX_START: begin
          if (centre) begin
            // A glitch that is high again at centre is no start bit
            rxState_q <= rxSync_q ? mdu_pkg::RX_IDLE : mdu_pkg::RX_DATA;
            rxBit_q <= '0;
          end
        end
        mdu_pkg::RX_DATA: begin
          if (centre) begin
            rxShift_q <= {rxSync_q, rxShift_q[7:1]};
            if (rxBit_q == 3'(mdu_pkg::CHAR_DATA_BITS - 1)) begin
              rxState_q <= mdu_pkg::RX_STOP;
            end
            rxBit_q <= rxBit_q + 1'b1;
          end
        end
        mdu_pkg::RX_STOP: begin
          if (centre) begin
            rxByteValid <= rxSync_q;
            rxByte <= rxShift_q;
            rxState_q <= mdu_pkg::RX_IDLE;
          end
        end
        default: rxState_q <= mdu_pkg::RX_IDLE;
      endcase
    end
  end
endmodule // mdu_midi_uart

// file: test/mdu_midi_uart_checker.sv
// Purpose: Port-level assertions for the MIDI UART emulation block
// Assumes: Sees only the top module ports; mode is rebuilt from command writes
// Notes: The high-run counter saturates so a long idle line never wraps it
`timescale 1ns/1ps
module mdu_midi_uart_checker #(
  parameter logic [9:0] PORT_BASE = 10'h330 // Base I/O address
) (
  input wire logic sys_clk, // System clock
  input wire logic rst_n, // Reset, active low
  input wire logic hostRd, // Read strobe
  input wire logic hostWr, // Write strobe
  input wire logic [15:0] hostAddr, // Host address
  input wire logic [7:0] hostWdata, // Write data
  input wire logic [7:0] hostRdata, // Read data
  input wire logic hostIrq, // Interrupt request
  input wire logic midi_serial_in, // Serial in
  input wire logic midi_serial_out // Serial out
);
  localparam int BITC = mdu_pkg::BIT_CYCLES;
  logic hit, dataHit, cmdHit, uartMode_q;
  logic [5:0] echo_q;
  int lowRun_q, highRun_q;
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Decode of both locations, ten bits with upper bits zero
  assign hit = hostAddr[15:10] == 6'h00 && hostAddr[9:1] == PORT_BASE[9:1];
  assign dataHit = hit && !hostAddr[0];
  assign cmdHit = hit && hostAddr[0];
  // Mode and echo follow what the host wrote
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      uartMode_q <= 1'b0;
      echo_q <= 6'h00;
    end else if (hostWr && cmdHit) begin
      echo_q <= hostWdata[5:0];
      if (!uartMode_q && hostWdata == mdu_pkg::CMD_ENTER_UART) uartMode_q <= 1'b1;
      if (uartMode_q && hostWdata == mdu_pkg::CMD_LEAVE_UART) uartMode_q <= 1'b0;
    end
  end
  // Low and high run lengths of the serial output; reset counts as long idle
  always_ff @(posedge sys_clk) begin
    if (!rst_n || midi_serial_out) lowRun_q <= 0;
    else lowRun_q <= lowRun_q + 1;
  end
  always_ff @(posedge sys_clk) begin
    if (!rst_n) highRun_q <= 11 * BITC;
    else if (!midi_serial_out) highRun_q <= 0;
    else if (highRun_q < 11 * BITC) highRun_q <= highRun_q + 1;
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence dataRdS;
    hostRd && dataHit && !hostWr;
  endsequence
  sequence peekS;
    (hostRd && dataHit && !hostWr && !uartMode_q) ##1 (hostRd && dataHit && !hostWr);
  endsequence
  cmd_ack_a: assert property (hostWr && cmdHit && !uartMode_q |=> hostIrq)
    else $error("no interrupt after a command");
  irq_clear_a: assert property (dataRdS |=> !hostIrq)
    else $error("interrupt not cleared by data read");
  status_echo_a: assert property (hostRd && cmdHit && !hostWr |=> hostRdata[5:0] == echo_q)
    else $error("status low bits differ from last command");
  alias_quiet_a: assert property (hostRd && !hit |=> $stable(hostRdata))
    else $error("undecoded read changed read data");
  peek_hold_a: assert property (peekS |=> hostRdata == $past(hostRdata))
    else $error("data read popped in non-uart mode");
  bit_run_a: assert property ($rose(midi_serial_out) |-> lowRun_q % BITC == 0 && lowRun_q >= BITC && lowRun_q <= 9 * BITC)
    else $error("serial low run not whole bits");
  stop_high_a: assert property ($fell(midi_serial_out) |-> highRun_q >= BITC)
    else $error("start bit without a full stop before it");
  tx_drop_a: assert property (hostWr && dataHit && !uartMode_q && highRun_q > 10 * BITC |=> midi_serial_out [*8])
    else $error("data written in non-uart mode was sent");
  tx_start_a: assert property (hostWr && dataHit && uartMode_q && highRun_q > 10 * BITC |-> ##[1:4] !midi_serial_out)
    else $error("queued byte did not start");
  uart_quiet_a: assert property (hostWr && cmdHit && uartMode_q && hostWdata != 8'hff && !hostIrq && midi_serial_in |=> !hostIrq [*3])
    else $error("command acknowledged in uart mode");
endmodule // mdu_midi_uart_checker

bind mdu_midi_uart mdu_midi_uart_checker #(.PORT_BASE(PORT_BASE)) mdu_midi_uart_checker_i (
  .sys_clk(sys_clk), .rst_n(rst_n), .hostRd(hostRd), .hostWr(hostWr), .hostAddr(hostAddr),
  .hostWdata(hostWdata), .hostRdata(hostRdata), .hostIrq(hostIrq),
  .midi_serial_in(midi_serial_in), .midi_serial_out(midi_serial_out));

// file: test/mdu_midi_partner.sv
// Purpose: Behavioural MIDI instrument at the far end of the serial link
// Assumes: 10 ns clock, so one bit lasts BITC clock periods
// Notes: Line idles high, as the opto-isolated input does with no current
`timescale 1ns/1ps
module mdu_midi_partner #(
  parameter int BITC = mdu_pkg::BIT_CYCLES // Clock periods per bit
) (
  input wire logic txLine, // Serial output of the block
  output logic rxLine, // Serial input of the block
  output logic [7:0] rxByte, // Last byte heard
  output int rxCount // Frames heard with a good stop bit
);
  localparam realtime BT = BITC * 10.0;
  // Idle line at time zero
  initial begin
    rxLine = 1'b1;
    rxByte = 8'h00;
    rxCount = 0;
  end
  // Listener samples bit centres; counts only after the whole stop bit
  always begin
    @(negedge txLine);
    #(BT / 2);
    for (int i = 0; i < 8; i++) begin
      #(BT);
      rxByte[i] = txLine;
    end
    #(BT);
    if (txLine === 1'b1) begin
      #(BT / 2);
      rxCount++;
    end
  end
  // Sender; a low stop bit makes a framing fault on purpose
  task automatic send(input logic [7:0] b, input logic stopBit);
    rxLine = 1'b0;
    #(BT);
    for (int i = 0; i < 8; i++) begin
      rxLine = b[i];
      #(BT);
    end
    rxLine = stopBit;
    #(BT);
    rxLine = 1'b1;
  endtask
endmodule // mdu_midi_partner

// file: test/mdu_midi_uart_test.sv
// Purpose: Self-checking bench for the MIDI UART emulation block
// Assumes: Default port base, 100 MHz clock, full-length bit timing
// Notes: Only the first of 65 queued transmit frames is awaited, with two receive frames, to keep the run short
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin errors++; $display("[ERR] t=%0t got=%h exp=%h", $time, (a), (b)); end end
module mdu_midi_uart_test;
  localparam logic [15:0] DATA_A = 16'h0330;
  localparam logic [15:0] CMD_A = 16'h0331;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic hostRd = 1'b0;
  logic hostWr = 1'b0;
  logic [15:0] hostAddr = 16'h0000;
  logic [7:0] hostWdata = 8'h00;
  logic [7:0] hostRdata, rv, peerByte;
  logic hostIrq, serIn, serOut;
  int peerCount;
  int errors = 0;
  int comparisons = 0;
  mdu_midi_uart mdu_midi_uart_i (.sys_clk(sys_clk), .rst_n(rst_n), .hostRd(hostRd), .hostWr(hostWr),
    .hostAddr(hostAddr), .hostWdata(hostWdata), .hostRdata(hostRdata), .hostIrq(hostIrq),
    .midi_serial_in(serIn), .midi_serial_out(serOut));
  mdu_midi_partner mdu_midi_partner_i (.txLine(serOut), .rxLine(serIn), .rxByte(peerByte), .rxCount(peerCount));
  // ----------------------------------------
  // Bus tasks
  // ----------------------------------------
  always #5 sys_clk = ~sys_clk;
  task automatic stop_test();
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // One-cycle write strobe; the closing edge keeps writes a cycle apart
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    hostWr <= 1'b1;
    hostAddr <= a;
    hostWdata <= d;
    @(posedge sys_clk);
    hostWr <= 1'b0;
  endtask
  // n back-to-back reads; the last answer is returned
  task automatic rd(input logic [15:0] a, input int n, output logic [7:0] d);
    @(posedge sys_clk);
    hostRd <= 1'b1;
    hostAddr <= a;
    repeat (n) @(posedge sys_clk);
    hostRd <= 1'b0;
    #1 d = hostRdata;
  endtask
  task automatic waitIrq();
    for (int i = 0; i < 40 && hostIrq !== 1'b1; i++) @(posedge sys_clk);
    if (hostIrq !== 1'b1) begin
      errors++;
      stop_test();
    end
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    rd(CMD_A, 1, rv);
    `CHK(rv, 8'h80)
    `CHK(hostIrq, 1'b0)
  endtask
  // Aliased and neighbouring addresses must stay silent
  task automatic t_alias();
    wr(CMD_A | 16'h0400, 8'h3f);
    wr(CMD_A ^ 16'h0002, 8'h3f);
    rd(CMD_A | 16'h0400, 1, rv);
    `CHK(rv, 8'h80)
    `CHK(hostIrq, 1'b0)
  endtask
  // Reply commands A0h, A7h, ABh, ACh, ADh and AFh, then an unlisted one; replies are drained in uart mode
  task automatic t_cmds();
    logic [7:0] cmd [7] = '{8'ha0, 8'ha7, 8'hab, 8'hac, 8'had, 8'haf, 8'h12};
    logic [7:0] rep [6] = '{8'h00, 8'h00, 8'h00, 8'h15, 8'h01, 8'h64};
    for (int i = 0; i < 7; i++) begin
      wr(CMD_A, cmd[i]);
      waitIrq();
      rd(CMD_A, 1, rv);
      `CHK(rv, {2'b00, cmd[i][5:0]})
      rd(DATA_A, 2, rv);
      `CHK(rv, 8'hfe)
      `CHK(hostIrq, 1'b0)
      wr(DATA_A, 8'h77);
      wr(CMD_A, 8'h3f);
      waitIrq();
      rd(DATA_A, 1, rv);
      `CHK(rv, 8'hfe)
      if (i < 6) begin
        rd(DATA_A, 1, rv);
        `CHK(rv, rep[i])
      end
      rd(DATA_A, 1, rv);
      `CHK(rv, 8'hfe)
      wr(CMD_A, 8'h55);
      rd(CMD_A, 1, rv);
      `CHK(rv, 8'h95)
      `CHK(hostIrq, 1'b0)
      wr(CMD_A, 8'hff);
    end
  endtask
  // Fill the transmit queue while a byte arrives from the partner
  task automatic t_txrx();
    int c0;
    wr(CMD_A, 8'h3f);
    waitIrq();
    rd(DATA_A, 1, rv);
    c0 = peerCount;
    fork
      mdu_midi_partner_i.send(8'h3c, 1'b1);
    join_none
    wr(DATA_A, 8'ha5);
    for (int i = 0; i < 64; i++) wr(DATA_A, 8'(i));
    rd(CMD_A, 1, rv);
    `CHK(rv, 8'hff)
    for (int n = 0; n < 40000 && peerCount == c0; n++) @(posedge sys_clk);
    if (peerCount == c0) begin
      errors++;
      stop_test();
    end
    `CHK(peerByte, 8'ha5)
    repeat (8) @(posedge sys_clk);
    waitIrq();
    rd(CMD_A, 1, rv);
    `CHK(rv, 8'h3f)
    rd(DATA_A, 1, rv);
    `CHK(rv, 8'h3c)
    `CHK(hostIrq, 1'b0)
  endtask
  // A frame with a low stop bit is dropped
  task automatic t_badstop();
    mdu_midi_partner_i.send(8'h5a, 1'b0);
    repeat (400) @(posedge sys_clk);
    `CHK(hostIrq, 1'b0)
    rd(CMD_A, 1, rv);
    `CHK(rv[7], 1'b1)
  endtask
  // Main sequence, with a second reset while frames are still going out
  initial begin
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_reset();
    t_alias();
    t_cmds();
    t_txrx();
    t_badstop();
    @(posedge sys_clk);
    rst_n <= 1'b0;
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_reset();
    stop_test();
  end
endmodule // mdu_midi_uart_test
